// ### design/tsc_pkg.sv
package tsc_pkg;
  // ********************
  // Timing
  // ********************
  localparam int CLK_HZ = 100_000_000; // System clock rate
  localparam int TERM_DELAY_MS = 1000; // Terminator delay
  localparam int TERM_DELAY_CYC = TERM_DELAY_MS * (CLK_HZ / 1000);
  localparam int HB_PERIOD_US = 100; // Health pulse period
  localparam int HB_PERIOD_CYC = HB_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int HB_TIMEOUT_US = 1000; // Missing health limit
  localparam int HB_TIMEOUT_CYC = HB_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int BAUD_RATE = 9600; // Remote link rate
  localparam int BAUD_DIV_CYC = CLK_HZ / BAUD_RATE;
  // ********************
  // Remote frame layout
  // ********************
  localparam int FRAME_DATA_W = 8; // Data bits per frame
  localparam int FRAME_RX_BITS = 10; // Data, parity, stop
  localparam int FRAME_TX_BITS = 11; // Start, data, parity, stop
  localparam int FRAME_PAR_POS = 8; // Parity bit index
  localparam int FRAME_STOP_POS = 9; // Stop bit index
  localparam int CMD_ON = 0; // Remote on request
  localparam int CMD_OFF = 1; // Remote off request
  localparam int CMD_CHG = 2; // Remote changeover
  localparam int CMD_ILK = 3; // Remote interlock
  localparam int STS_TX1 = 0; // Status: transmitter 1 on
  localparam int STS_TX2 = 1; // Status: transmitter 2 on
  localparam int STS_ANT = 2; // Status: antenna select
  localparam int STS_SHUT = 3; // Status: shut down
  localparam int STS_TERM = 4; // Status: terminator tripped
  localparam int STS_RERR = 5; // Status: link error
  localparam int STS_ALM1 = 6; // Status: alarm 1
  localparam int STS_ALM2 = 7; // Status: alarm 2
  localparam int LAMP_W = 4; // Warning lamp count
  localparam logic RST_ANT = 1'b0; // Antenna on transmitter 1
  localparam logic LINE_IDLE = 1'b1; // Idle serial level
  typedef enum logic [1:0] {TSC_OFF, TSC_ON1, TSC_ON2, TSC_SHUT} tsc_mode_t;
  typedef enum logic [1:0] {TSC_RX_IDLE, TSC_RX_START, TSC_RX_BITS} tsc_rx_t;
endpackage : tsc_pkg

// ### design/tsc_rc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tsc_rc_if;
  import tsc_pkg::*;
  logic cmd_vld; // Good command frame, one cycle
  logic [FRAME_DATA_W-1:0] cmd; // Command byte
  logic err; // Bad frame, one cycle
  logic [FRAME_DATA_W-1:0] status; // Status byte to send
  modport link (output cmd_vld, cmd, err, input status);
  modport user (input cmd_vld, cmd, err, output status);
  modport tap (input cmd_vld, cmd);
endinterface : tsc_rc_if
`default_nettype wire

// ### design/tsc_remote_link.sv
`timescale 1ns/1ns
`default_nettype none
module tsc_remote_link
  import tsc_pkg::*;
#(
  parameter int BAUD_DIV = BAUD_DIV_CYC
)
(
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic rx, // Serial in
  output logic tx, // Serial out
  tsc_rc_if.link rc // Command and status
);
  localparam int CW = $clog2(BAUD_DIV + 1);
  if (BAUD_DIV < 4)
  begin : g_chk
    $error("BAUD_DIV too small");
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  tsc_rx_t r_st_q, r_st_d;
  logic [CW-1:0] r_cnt_q, r_cnt_d, t_cnt_q, t_cnt_d;
  logic [3:0] r_bit_q, r_bit_d, t_bit_q, t_bit_d;
  logic [FRAME_RX_BITS-1:0] r_sh_q, r_sh_d, fr;
  logic [FRAME_TX_BITS-1:0] t_sh_q, t_sh_d;
  logic vld_q, vld_d, err_q, err_d, tx_q, tx_d;
  logic [FRAME_DATA_W-1:0] cmd_q, cmd_d;

  // Receive and send next state, even parity
  always_comb
  begin
    r_st_d = r_st_q;
    r_cnt_d = (r_cnt_q != '0) ? r_cnt_q - 1'b1 : r_cnt_q;
    r_bit_d = r_bit_q;
    r_sh_d = r_sh_q;
    cmd_d = cmd_q;
    vld_d = 1'b0;
    err_d = 1'b0;
    fr = {rx, r_sh_q[FRAME_RX_BITS-1:1]};
    case (r_st_q)
      TSC_RX_IDLE:
        if (rx != LINE_IDLE)
        begin
          r_st_d = TSC_RX_START;
          r_cnt_d = CW'(BAUD_DIV / 2);
        end
      TSC_RX_START:
        if (r_cnt_q == '0)
        begin
          r_st_d = (rx == LINE_IDLE) ? TSC_RX_IDLE : TSC_RX_BITS;
          r_cnt_d = CW'(BAUD_DIV - 1);
          r_bit_d = '0;
        end
      default:
        if (r_cnt_q == '0)
        begin
          r_sh_d = fr;
          r_cnt_d = CW'(BAUD_DIV - 1);
          r_bit_d = r_bit_q + 1'b1;
          if (r_bit_q == 4'(FRAME_STOP_POS))
          begin
            r_st_d = TSC_RX_IDLE;
            if ((^fr[FRAME_PAR_POS:0]) || !fr[FRAME_STOP_POS])
              err_d = 1'b1;
            else
            begin
              vld_d = 1'b1;
              cmd_d = fr[FRAME_DATA_W-1:0];
            end
          end
        end
    endcase
    t_cnt_d = (t_cnt_q == '0) ? CW'(BAUD_DIV - 1) : t_cnt_q - 1'b1;
    t_sh_d = t_sh_q;
    t_bit_d = t_bit_q;
    tx_d = tx_q;
    if (t_cnt_q == '0)
    begin
      if (t_bit_q == '0)
      begin
        t_sh_d = {LINE_IDLE, ^rc.status, rc.status, 1'b0};
        t_bit_d = 4'(FRAME_TX_BITS);
      end
      else
      begin
        tx_d = t_sh_q[0];
        t_sh_d = {LINE_IDLE, t_sh_q[FRAME_TX_BITS-1:1]};
        t_bit_d = t_bit_q - 1'b1;
      end
    end
  end

  // Link registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      r_st_q <= TSC_RX_IDLE;
      r_cnt_q <= '0;
      r_bit_q <= '0;
      r_sh_q <= '0;
      cmd_q <= '0;
      vld_q <= 1'b0;
      err_q <= 1'b0;
      t_cnt_q <= '0;
      t_bit_q <= '0;
      t_sh_q <= '1;
      tx_q <= LINE_IDLE;
    end
    else
    begin
      r_st_q <= r_st_d;
      r_cnt_q <= r_cnt_d;
      r_bit_q <= r_bit_d;
      r_sh_q <= r_sh_d;
      cmd_q <= cmd_d;
      vld_q <= vld_d;
      err_q <= err_d;
      t_cnt_q <= t_cnt_d;
      t_bit_q <= t_bit_d;
      t_sh_q <= t_sh_d;
      tx_q <= tx_d;
    end
  end

  assign tx = tx_q;
  assign rc.cmd_vld = vld_q;
  assign rc.cmd = cmd_q;
  assign rc.err = err_q;

  a_stop_error: assert property (
    r_st_q == TSC_RX_BITS && r_cnt_q == '0 && r_bit_q == 4'(FRAME_STOP_POS) && !rx |=> err_q && !vld_q)
    else $error("low stop bit not flagged");
endmodule : tsc_remote_link
`default_nettype wire

// ### design/tsc_terminator.sv
`timescale 1ns/1ns
`default_nettype none
module tsc_terminator
  import tsc_pkg::*;
#(
  parameter int DELAY = TERM_DELAY_CYC,
  parameter int HB_TIMEOUT = HB_TIMEOUT_CYC
)
(
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  tsc_rc_if.tap rc, // Remote commands
  input wire logic alarm, // Alarm seen by terminator
  input wire logic hb, // Controller health pulse
  output logic trip // Power removal, sticky
);
  localparam int DW = $clog2(DELAY + 1);
  localparam int HW = $clog2(HB_TIMEOUT + 1);
  if (DELAY < 1 || HB_TIMEOUT < 2)
  begin : g_chk
    $error("terminator counts too small");
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic [DW-1:0] dly_q, dly_d;
  logic [HW-1:0] age_q, age_d;
  logic ilk_q, ilk_d, trip_q, trip_d, cond;

  // Own copy of interlock, delay and health watch
  always_comb
  begin
    ilk_d = rc.cmd_vld ? rc.cmd[CMD_ILK] : ilk_q;
    cond = alarm || ilk_q;
    dly_d = '0;
    if (cond && dly_q != DW'(DELAY - 1))
      dly_d = dly_q + 1'b1;
    else if (cond)
      dly_d = dly_q;
    age_d = hb ? '0 : ((age_q == HW'(HB_TIMEOUT - 1)) ? age_q : age_q + 1'b1);
    trip_d = trip_q || (cond && dly_q == DW'(DELAY - 1))
             || (!hb && age_q == HW'(HB_TIMEOUT - 1));
  end

  // Terminator registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ilk_q <= 1'b0;
      dly_q <= '0;
      age_q <= '0;
      trip_q <= 1'b0;
    end
    else
    begin
      ilk_q <= ilk_d;
      dly_q <= dly_d;
      age_q <= age_d;
      trip_q <= trip_d;
    end
  end

  assign trip = trip_q;

  a_trip_delay: assert property (
    cond && dly_q == DW'(DELAY - 1) |=> trip_q)
    else $error("no trip after delay");
  a_delay_restart: assert property (
    !cond |=> dly_q == '0)
    else $error("delay not restarted");
  a_trip_sticky: assert property (
    trip_q |=> trip_q)
    else $error("trip released");
  a_health_lost: assert property (
    !hb && age_q == HW'(HB_TIMEOUT - 1) |=> trip_q)
    else $error("missing health not caught");
  a_ilk_copy: assert property (
    rc.cmd_vld |=> ilk_q == $past(rc.cmd[CMD_ILK]))
    else $error("interlock not taken");
endmodule : tsc_terminator
`default_nettype wire

// ### design/tsc_station_control.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Alarm and mode pick changeover or shutdown
// - Alarms, remote, panel, maintenance govern on/off
// - Independent terminator shuts down on controller failure
// - Terminator cuts power one second after alarm
// - Remote link converts serial, flags bad frames
// - Remote commands reach controller and terminator
// - Maintenance port reads state, sets lamps
// - One antenna select drives changeover relays
// - Board configuration alters controller decisions
// - Panel shows status, forwards operator keys
// - Terminator alarm cuts amplifier supply
module tsc_station_control
  import tsc_pkg::*;
#(
  parameter int TERM_DELAY = TERM_DELAY_CYC, // Terminator delay, cycles
  parameter int HB_PERIOD = HB_PERIOD_CYC, // Health pulse period, cycles
  parameter int HB_TIMEOUT = HB_TIMEOUT_CYC, // Health loss limit, cycles
  parameter int BAUD_DIV = BAUD_DIV_CYC // Cycles per serial bit
)
(
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic mon_alarm1, // Monitor alarm, transmitter 1
  input wire logic mon_alarm2, // Monitor alarm, transmitter 2
  input wire logic remote_rx, // Serial from remote unit
  output logic remote_tx, // Serial to remote unit
  input wire logic panel_on, // Panel on key
  input wire logic panel_off, // Panel off key
  input wire logic panel_change, // Panel changeover key
  input wire logic maint_on, // Maintenance on request
  input wire logic maint_off, // Maintenance off request
  input wire logic maint_change, // Maintenance changeover request
  input wire logic maint_lamp_wr, // Lamp write strobe
  input wire logic [LAMP_W-1:0] maint_lamp_data, // Lamp write data
  input wire logic cfg_auto_change, // Change to standby on alarm
  input wire logic cfg_remote_en, // Obey remote on/off/change
  input wire logic cfg_pref_tx2, // Start on transmitter 2
  output logic tx1_on, // Transmitter 1 enable
  output logic tx2_on, // Transmitter 2 enable
  output logic ant_relay_sel, // Antenna relay: 1 = transmitter 2
  output logic term_alarm, // Amplifier supply cut
  output logic [FRAME_DATA_W-1:0] maint_state, // Controller state word
  output logic [LAMP_W-1:0] maint_lamps, // Warning lamps
  output logic [FRAME_DATA_W-1:0] panel_leds, // Panel status lights
  output logic remote_err // Last remote frame bad
);
  localparam int HPW = $clog2(HB_PERIOD + 1);
  if (HB_PERIOD < 2 || HB_PERIOD >= HB_TIMEOUT)
  begin : g_chk
    $error("health period must be below timeout");
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ********************
  // Remote link and terminator
  // ********************
  tsc_rc_if rc ();
  logic hb_q, hb_d, term_in;

  // Serial conversion both ways
  tsc_remote_link #(
    .BAUD_DIV(BAUD_DIV)
  ) u_link (
    .mclk(mclk),
    .srst(srst),
    .rx(remote_rx),
    .tx(remote_tx),
    .rc(rc.link)
  );

  // Independent shutdown path
  tsc_terminator #(
    .DELAY(TERM_DELAY),
    .HB_TIMEOUT(HB_TIMEOUT)
  ) u_term (
    .mclk(mclk),
    .srst(srst),
    .rc(rc.tap),
    .alarm(term_in),
    .hb(hb_q),
    .trip(term_alarm)
  );

  // ********************
  // Request merge
  // ********************
  tsc_mode_t mode_q, mode_d;
  logic changed_q, changed_d, ilk_q, ilk_d, rerr_q, rerr_d;
  logic ant_q, ant_d, tx1_q, tx1_d, tx2_q, tx2_d;
  logic [LAMP_W-1:0] lamps_q, lamps_d;
  logic [FRAME_DATA_W-1:0] sts_q, sts_d, mst_q, mst_d;
  logic rem_ok, on_req, off_req, chg_req, alm_act, alm_stby, running;
  logic [HPW-1:0] hbc_q, hbc_d;

  // Three sources feed each request
  always_comb
  begin
    rem_ok = rc.cmd_vld && cfg_remote_en;
    on_req = panel_on || maint_on || (rem_ok && rc.cmd[CMD_ON]);
    off_req = panel_off || maint_off || (rem_ok && rc.cmd[CMD_OFF]);
    chg_req = panel_change || maint_change || (rem_ok && rc.cmd[CMD_CHG]);
    alm_act = ant_q ? mon_alarm2 : mon_alarm1;
    alm_stby = ant_q ? mon_alarm1 : mon_alarm2;
    running = (mode_q == TSC_ON1) || (mode_q == TSC_ON2);
  end

  // ********************
  // Station control state
  // ********************
  // Interlock first, then alarm, off, change, on
  always_comb
  begin
    mode_d = mode_q;
    changed_d = changed_q;
    ilk_d = rc.cmd_vld ? rc.cmd[CMD_ILK] : ilk_q;
    case (mode_q)
      TSC_OFF:
        if (on_req && !ilk_q)
        begin
          mode_d = cfg_pref_tx2 ? TSC_ON2 : TSC_ON1;
          changed_d = 1'b0;
        end
      TSC_ON1, TSC_ON2:
        if (ilk_q)
          mode_d = TSC_SHUT;
        else if (alm_act)
        begin
          if (cfg_auto_change && !changed_q && !alm_stby)
          begin
            mode_d = (mode_q == TSC_ON1) ? TSC_ON2 : TSC_ON1;
            changed_d = 1'b1;
          end
          else
            mode_d = TSC_SHUT;
        end
        else if (off_req)
          mode_d = TSC_OFF;
        else if (chg_req)
          mode_d = (mode_q == TSC_ON1) ? TSC_ON2 : TSC_ON1;
      default:
        if (off_req)
          mode_d = TSC_OFF;
    endcase
  end

  // Relay select and enables follow the next mode
  always_comb
  begin
    ant_d = ant_q;
    if (mode_d == TSC_ON1)
      ant_d = 1'b0;
    else if (mode_d == TSC_ON2)
      ant_d = 1'b1;
    tx1_d = (mode_d == TSC_ON1);
    tx2_d = (mode_d == TSC_ON2);
    term_in = (mode_q == TSC_SHUT) || (running && alm_act);
  end

  // ********************
  // Health pulse
  // ********************
  // Pulse every period in every mode, while out of reset
  always_comb
  begin
    hbc_d = hbc_q + 1'b1;
    hb_d = 1'b0;
    if (hbc_q == HPW'(HB_PERIOD - 1))
    begin
      hbc_d = '0;
      hb_d = 1'b1;
    end
  end

  // ********************
  // Status, lamps, link error
  // ********************
  // Lamp register, link error flag, status and state words
  always_comb
  begin
    lamps_d = maint_lamp_wr ? maint_lamp_data : lamps_q;
    rerr_d = rc.err || (rerr_q && !rc.cmd_vld);
    sts_d = '0;
    sts_d[STS_TX1] = tx1_q;
    sts_d[STS_TX2] = tx2_q;
    sts_d[STS_ANT] = ant_q;
    sts_d[STS_SHUT] = (mode_q == TSC_SHUT);
    sts_d[STS_TERM] = term_alarm;
    sts_d[STS_RERR] = rerr_q;
    sts_d[STS_ALM1] = mon_alarm1;
    sts_d[STS_ALM2] = mon_alarm2;
    mst_d = {ilk_q, changed_q, rerr_q, term_alarm, ant_q, 1'b0, mode_q};
  end

  // Controller registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mode_q <= TSC_OFF;
      changed_q <= 1'b0;
      ilk_q <= 1'b0;
      ant_q <= RST_ANT;
      tx1_q <= 1'b0;
      tx2_q <= 1'b0;
      hbc_q <= '0;
      hb_q <= 1'b0;
      lamps_q <= '0;
      rerr_q <= 1'b0;
      sts_q <= '0;
      mst_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      changed_q <= changed_d;
      ilk_q <= ilk_d;
      ant_q <= ant_d;
      tx1_q <= tx1_d;
      tx2_q <= tx2_d;
      hbc_q <= hbc_d;
      hb_q <= hb_d;
      lamps_q <= lamps_d;
      rerr_q <= rerr_d;
      sts_q <= sts_d;
      mst_q <= mst_d;
    end
  end

  // Outputs from registers
  assign tx1_on = tx1_q;
  assign tx2_on = tx2_q;
  assign ant_relay_sel = ant_q;
  assign maint_lamps = lamps_q;
  assign maint_state = mst_q;
  assign panel_leds = sts_q;
  assign remote_err = rerr_q;
  assign rc.status = sts_q;

  // ********************
  // Checks
  // ********************
  a_alarm_change: assert property (
    mode_q == TSC_ON1 && !ilk_q && mon_alarm1 && !mon_alarm2 && cfg_auto_change && !changed_q
    |=> mode_q == TSC_ON2 && tx2_on && ant_relay_sel)
    else $error("no changeover on alarm");
  a_alarm_shut: assert property (
    running && alm_act && !cfg_auto_change |=> mode_q == TSC_SHUT && !tx1_on && !tx2_on)
    else $error("no shutdown on alarm");
  a_panel_on: assert property (
    mode_q == TSC_OFF && panel_on && !ilk_q && !cfg_pref_tx2 |=> mode_q == TSC_ON1)
    else $error("panel on ignored");
  a_maint_off: assert property (
    running && !ilk_q && !alm_act && maint_off |=> mode_q == TSC_OFF)
    else $error("maintenance off ignored");
  a_relay_route: assert property (
    tx2_on |-> ant_relay_sel && !tx1_on)
    else $error("relay not on running transmitter");
  a_lamp_write: assert property (
    maint_lamp_wr |=> maint_lamps == $past(maint_lamp_data))
    else $error("lamp write lost");
  a_link_error: assert property (
    rc.err |=> remote_err [*2])
    else $error("link error not shown");
  a_health_pulse: assert property (
    hb_q |=> !hb_q)
    else $error("health pulse too long");
  a_ilk_shut: assert property (
    running && ilk_q |=> mode_q == TSC_SHUT && !tx1_on && !tx2_on)
    else $error("interlock did not shut down");
  a_shut_hold: assert property (
    mode_q == TSC_SHUT && !off_req |=> mode_q == TSC_SHUT)
    else $error("shutdown left without off");
  a_second_alarm: assert property (
    running && changed_q && alm_act && !ilk_q |=> mode_q == TSC_SHUT)
    else $error("second alarm did not shut down");
  a_off_from_shut: assert property (
    mode_q == TSC_SHUT && off_req |=> mode_q == TSC_OFF)
    else $error("off request ignored in shutdown");
  a_change_swap: assert property (
    mode_q == TSC_ON1 && chg_req && !off_req && !alm_act && !ilk_q |=> mode_q == TSC_ON2)
    else $error("change request ignored");
  a_remote_on: assert property (
    mode_q == TSC_OFF && rc.cmd_vld && cfg_remote_en && rc.cmd[CMD_ON] && !ilk_q |=> running)
    else $error("remote on ignored");
  a_remote_refused: assert property (
    mode_q == TSC_OFF && rc.cmd_vld && !cfg_remote_en && !panel_on && !maint_on |=> mode_q == TSC_OFF)
    else $error("disabled remote obeyed");
  a_err_clear: assert property (
    rc.cmd_vld |=> !remote_err)
    else $error("good frame left link error");
  a_lamp_hold: assert property (
    !maint_lamp_wr |=> $stable(maint_lamps))
    else $error("lamps changed without write");
  a_state_mode: assert property (
    1'b1 |=> maint_state[1:0] == $past(mode_q))
    else $error("state word mode wrong");
  a_status_shut: assert property (
    mode_q == TSC_SHUT |=> panel_leds[STS_SHUT])
    else $error("shutdown not shown");
endmodule : tsc_station_control
`default_nettype wire

// ### dv/tsc_remote_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************
// Remote unit model
// ********************
module tsc_remote_model
  import tsc_pkg::*;
#(
  parameter int BAUD_DIV = 8 // Cycles per serial bit
)
(
  input wire logic mclk, // System clock
  output logic rx_line, // Serial to station
  input wire logic tx_line // Serial from station
);
  // Line rests at its idle level
  initial rx_line = LINE_IDLE;

  // Key and interlock frame: start, data LSB first, even parity, stop; bad[0] spoils parity, bad[1] the stop
  task automatic send_frame(input logic [FRAME_DATA_W-1:0] d, input logic [1:0] bad);
    logic [FRAME_TX_BITS-1:0] f;
    f = {LINE_IDLE ^ bad[1], (^d) ^ bad[0], d, 1'b0};
    for (int i = 0; i < FRAME_TX_BITS; i++)
    begin
      @(negedge mclk);
      rx_line = f[i];
      repeat (BAUD_DIV - 1) @(negedge mclk);
    end
    // Back to idle, so a spoilt stop bit is not held as a start
    @(negedge mclk);
    rx_line = LINE_IDLE;
  endtask : send_frame

  // Status frame: find the gap, then sample mid-bit on falling edges, away from the launch edge
  task automatic recv_frame(output logic [FRAME_DATA_W-1:0] d, output logic perr);
    logic [FRAME_RX_BITS-1:0] r;
    int cnt;
    cnt = 0;
    while (cnt < 2 * BAUD_DIV)
    begin
      @(negedge mclk);
      cnt = (tx_line === 1'b1) ? cnt + 1 : 0;
    end
    while (tx_line !== 1'b0) @(negedge mclk);
    repeat (BAUD_DIV / 2) @(negedge mclk);
    for (int i = 0; i < FRAME_RX_BITS; i++)
    begin
      repeat (BAUD_DIV) @(negedge mclk);
      r[i] = tx_line;
    end
    d = r[FRAME_DATA_W-1:0];
    perr = (^r[FRAME_PAR_POS:0]) | ~r[FRAME_STOP_POS];
  endtask : recv_frame
endmodule : tsc_remote_model
`default_nettype wire

// ### dv/test_transmitter_station_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_transmitter_station_control;
  import tsc_pkg::*;
  localparam int TD = 50;
  localparam int BD = 8;
  logic mclk, srst, mon_alarm1, mon_alarm2, remote_rx, remote_tx;
  logic panel_on, panel_off, panel_change, maint_on, maint_off, maint_change, maint_lamp_wr;
  logic [LAMP_W-1:0] maint_lamp_data, maint_lamps;
  logic cfg_auto_change, cfg_remote_en, cfg_pref_tx2;
  logic tx1_on, tx2_on, ant_relay_sel, term_alarm, remote_err, rperr;
  logic [FRAME_DATA_W-1:0] maint_state, panel_leds, rbyte;
  int err_count, checks_done;

  // ********************
  // Design and far side
  // ********************
  tsc_station_control #(.TERM_DELAY(TD), .HB_PERIOD(8), .HB_TIMEOUT(40), .BAUD_DIV(BD)) i_dut (
    .mclk(mclk), .srst(srst), .mon_alarm1(mon_alarm1), .mon_alarm2(mon_alarm2),
    .remote_rx(remote_rx), .remote_tx(remote_tx), .panel_on(panel_on), .panel_off(panel_off),
    .panel_change(panel_change), .maint_on(maint_on), .maint_off(maint_off),
    .maint_change(maint_change), .maint_lamp_wr(maint_lamp_wr), .maint_lamp_data(maint_lamp_data),
    .cfg_auto_change(cfg_auto_change), .cfg_remote_en(cfg_remote_en), .cfg_pref_tx2(cfg_pref_tx2),
    .tx1_on(tx1_on), .tx2_on(tx2_on), .ant_relay_sel(ant_relay_sel), .term_alarm(term_alarm),
    .maint_state(maint_state), .maint_lamps(maint_lamps), .panel_leds(panel_leds),
    .remote_err(remote_err));
  tsc_remote_model #(.BAUD_DIV(BD)) i_rem (.mclk(mclk), .rx_line(remote_rx), .tx_line(remote_tx));

  // Clock, 10 ns period
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********************
  // Helpers
  // ********************
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic do_reset();
    srst = 1'b1;
    tick(16);
    srst = 1'b0;
  endtask : do_reset

  // One-cycle request; 0..5 = panel on/off/change, maint on/off/change
  task automatic press(input int k);
    @(negedge mclk);
    {panel_on, panel_off, panel_change, maint_on, maint_off, maint_change} = 6'h20 >> k;
    @(negedge mclk);
    {panel_on, panel_off, panel_change, maint_on, maint_off, maint_change} = 6'h00;
  endtask : press

  // Cycles until power removal must fall in [lo, hi]
  task automatic wait_trip(input int lo, input int hi);
    int n;
    n = 0;
    while (term_alarm !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    check(8'((n >= lo) && (n <= hi)), 8'h01);
  endtask : wait_trip

  function automatic logic [7:0] outs();
    return {4'h0, term_alarm, tx1_on, tx2_on, ant_relay_sel};
  endfunction : outs

  // ********************
  // Tests
  // ********************
  initial
  begin
    err_count = 0;
    checks_done = 0;
    srst = 1'b1;
    {mon_alarm1, mon_alarm2, maint_lamp_wr, maint_lamp_data} = 7'h00;
    {panel_on, panel_off, panel_change, maint_on, maint_off, maint_change} = 6'h00;
    {cfg_auto_change, cfg_remote_en, cfg_pref_tx2} = 3'b100;
    do_reset();
    check(outs(), 8'h00);
    check(maint_state, 8'h00);
    check(8'(remote_tx), 8'h01);
    $display("test reset done");
    // On, status out, alarm changeover, second alarm shutdown
    press(0);
    check(outs(), 8'h04);
    tick(1);
    check(panel_leds, 8'h01);
    check(maint_state, 8'h01);
    i_rem.recv_frame(rbyte, rperr);
    i_rem.recv_frame(rbyte, rperr);
    check(rbyte, 8'h01);
    check(8'(rperr), 8'h00);
    mon_alarm1 = 1'b1;
    tick(1);
    check(outs(), 8'h03);
    tick(1);
    check(maint_state, 8'h4A);
    check(panel_leds, 8'h46);
    mon_alarm2 = 1'b1;
    tick(1);
    check(outs(), 8'h01);
    wait_trip(TD - 3, TD + 3);
    press(1);
    check(outs(), 8'h09);
    $display("test changeover done");
    {mon_alarm1, mon_alarm2} = 2'b00;
    do_reset();
    // Shutdown without changeover, count restarts after clearing
    cfg_auto_change = 1'b0;
    press(0);
    mon_alarm1 = 1'b1;
    tick(1);
    check(outs(), 8'h00);
    mon_alarm1 = 1'b0;
    tick(TD - 20);
    press(1);
    tick(1);
    check(maint_state, 8'h00);
    tick(150);
    check(8'(term_alarm), 8'h00);
    press(0);
    mon_alarm1 = 1'b1;
    tick(1);
    mon_alarm1 = 1'b0;
    wait_trip(TD - 3, TD + 3);
    $display("test restart done");
    do_reset();
    // Preferred transmitter, maintenance requests, lamps
    cfg_pref_tx2 = 1'b1;
    press(3);
    check(outs(), 8'h03);
    tick(1);
    check(maint_state, 8'h0A);
    press(2);
    check(outs(), 8'h04);
    press(5);
    check(outs(), 8'h03);
    press(4);
    check(outs(), 8'h01);
    maint_lamp_data = 4'hA;
    maint_lamp_wr = 1'b1;
    tick(1);
    maint_lamp_wr = 1'b0;
    tick(1);
    check(8'(maint_lamps), 8'h0A);
    check(8'(term_alarm), 8'h00);
    cfg_pref_tx2 = 1'b0;
    $display("test maintenance done");
    // Remote commands, refusal, bad frames, interlock
    cfg_remote_en = 1'b0;
    i_rem.send_frame(8'h01, 2'h0);
    tick(6);
    check(outs(), 8'h01);
    cfg_remote_en = 1'b1;
    i_rem.send_frame(8'h01, 2'h0);
    tick(6);
    check(outs(), 8'h04);
    i_rem.send_frame(8'h02, 2'h1);
    tick(6);
    check(8'(remote_err), 8'h01);
    check(outs(), 8'h04);
    i_rem.send_frame(8'h02, 2'h0);
    tick(6);
    check(8'(remote_err), 8'h00);
    check(outs(), 8'h00);
    i_rem.send_frame(8'h01, 2'h2);
    tick(6);
    check(8'(remote_err), 8'h01);
    check(outs(), 8'h00);
    i_rem.send_frame(8'h09, 2'h0);
    tick(6);
    check(maint_state & 8'h83, 8'h83);
    check(outs() & 8'h07, 8'h00);
    wait_trip(0, TD + 3);
    $display("test remote done");
    stop_test();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end
endmodule : test_transmitter_station_control
`default_nettype wire
